// ==== hw/hspc_pkg.sv ====
/*
 package for the halt/standby power controller: core states, pin
 defaults, reset vector, synchroniser depth.
 assumes a single 40 MHz core clock.
*/
package hspc_pkg;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 25;
  // instructions to complete after waking, before the interrupt sequence
  localparam logic [1:0] WAKE_INT_STEPS = 2'h2;
  localparam logic LATCH_STROBE_HALT = 1'b0;
  localparam logic CTRL_STROBE_HALT = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSPC_RUN,
    HSPC_HALT,
    HSPC_WAKE_INT,
    HSPC_IN_RESET,
    HSPC_STANDBY
  } hspc_state_e;

  typedef struct packed {
    logic latch_strobe;
    logic program_fetch_strobe;
    logic read_strobe;
    logic write_strobe;
    logic expander_strobe;
  } hspc_strobes_s;

endpackage

// ==== hw/hspc_sync.sv ====
/*
 two flop synchroniser for one asynchronous pin level.
 assumes the pin idles at the given reset level.
*/
`timescale 1ns/1ps
module hspc_sync #(
  parameter logic RESET_LEVEL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_sync
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule

// ==== hw/hspc_top.sv ====
/*
 halt and standby power controller of the 8-bit core. gates the core
 clock enable, holds pin states in halt, sequences reset and standby.
 assumes the core reports halt_exec, instr_done and int_enabled on
 clk, and that reset, standby, interrupt and count pins are async.
*/
`timescale 1ns/1ps
// Function
// - halt instruction stops fetch and execution
// - halt keeps only oscillator clock running
// - registers keep values across halt
// - halt pin states: bus, strobes held
// - test pin clock output continues in halt
// - event counter catches first pulse; timer stops
// - reset low ends halt, restarts at zero
// - interrupt enabled: two instructions, then interrupt
// - interrupt disabled: resume after halt instruction
// - standby stops everything, keeps data memory
// - standby exit: standby high, then reset high
module hspc_top
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic standby_pin,
  input wire logic int_pin_b,
  input wire logic count_input_pin,
  input wire logic halt_exec,
  input wire logic instr_done,
  input wire logic int_enabled,
  input wire logic counter_mode,
  input wire logic t0_clk_enable,
  input wire logic core_clk_phase,
  input wire logic bus_out_mode,
  input wire hspc_pkg::hspc_strobes_s core_strobes,
  output logic core_run_en,
  output logic core_reset,
  output logic ram_hold,
  output logic osc_run,
  output logic start_int_seq,
  output logic [10:0] pc_load_value,
  output logic pc_load,
  output logic count_event,
  output logic timer_run_en,
  output logic test_pin_zero_o,
  output logic test_pin_zero_oe,
  output logic bus_oe,
  output hspc_pkg::hspc_strobes_s pin_strobes
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic reset_s;
  logic standby_s;
  logic int_s;
  logic count_s;

  hspc_sync #(.RESET_LEVEL(1'b0)) u_sync_rst (
    .clk(clk), .rst_b(rst_b), .pin_in(reset_pin_b), .pin_sync(reset_s));
  hspc_sync #(.RESET_LEVEL(1'b1)) u_sync_standby_pin (
    .clk(clk), .rst_b(rst_b), .pin_in(standby_pin), .pin_sync(standby_s));
  hspc_sync #(.RESET_LEVEL(1'b1)) u_sync_int (
    .clk(clk), .rst_b(rst_b), .pin_in(int_pin_b), .pin_sync(int_s));
  hspc_sync #(.RESET_LEVEL(1'b0)) u_sync_cnt (
    .clk(clk), .rst_b(rst_b), .pin_in(count_input_pin),
    .pin_sync(count_s));

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  hspc_pkg::hspc_state_e state_reg, state_next;
  logic [1:0] steps_reg, steps_next;
  logic count_prev_reg, count_prev_next;
  logic halt_pulse_reg, halt_pulse_next;
  logic bus_mode_reg, bus_mode_next;

  always_comb
  begin
    state_next = state_reg;
    steps_next = steps_reg;
    count_prev_next = count_s;
    halt_pulse_next = 1'b0;
    bus_mode_next = bus_mode_reg;
    unique case (state_reg)
      hspc_pkg::HSPC_RUN:
      begin
        if (halt_exec)
        begin
          state_next = hspc_pkg::HSPC_HALT;
          bus_mode_next = bus_out_mode;
        end
      end
      hspc_pkg::HSPC_HALT:
      begin
        // first count edge in halt is kept for the counter
        if (counter_mode && count_s && !count_prev_reg)
          halt_pulse_next = 1'b1;
        if (!int_s)
        begin
          if (int_enabled)
          begin
            state_next = hspc_pkg::HSPC_WAKE_INT;
            steps_next = hspc_pkg::WAKE_INT_STEPS;
          end
          else
            state_next = hspc_pkg::HSPC_RUN;
        end
      end
      hspc_pkg::HSPC_WAKE_INT:
      begin
        if (instr_done)
        begin
          steps_next = steps_reg - 2'h1;
          if (steps_reg == 2'h1)
            state_next = hspc_pkg::HSPC_RUN;
        end
      end
      hspc_pkg::HSPC_IN_RESET:
      begin
        if (!standby_s)
          state_next = hspc_pkg::HSPC_STANDBY;
        else if (reset_s)
          state_next = hspc_pkg::HSPC_RUN;
      end
      hspc_pkg::HSPC_STANDBY:
      begin
        // leave only via standby high first, reset still low
        if (standby_s)
          state_next = hspc_pkg::HSPC_IN_RESET;
      end
    endcase
    // reset low overrides all but standby; standby low alone is ignored
    if (!reset_s && state_reg != hspc_pkg::HSPC_STANDBY
        && state_reg != hspc_pkg::HSPC_IN_RESET)
      state_next = hspc_pkg::HSPC_IN_RESET;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= hspc_pkg::HSPC_IN_RESET;
      steps_reg <= 2'h0;
      count_prev_reg <= 1'b0;
      halt_pulse_reg <= 1'b0;
      bus_mode_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      steps_reg <= steps_next;
      count_prev_reg <= count_prev_next;
      halt_pulse_reg <= halt_pulse_next;
      bus_mode_reg <= bus_mode_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic halted;
  logic in_reset_leave;
  logic in_standby;
  logic fired_reg;
  logic fired_next;

  assign halted = (state_reg == hspc_pkg::HSPC_HALT);
  assign in_standby = (state_reg == hspc_pkg::HSPC_STANDBY);
  assign in_reset_leave = (state_reg == hspc_pkg::HSPC_IN_RESET)
    && (state_next == hspc_pkg::HSPC_RUN);

  // only one pulse per halt, counting resumes normally afterwards
  always_comb
  begin
    fired_next = fired_reg;
    if (!halted)
      fired_next = 1'b0;
    else if (halt_pulse_reg)
      fired_next = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fired_reg <= 1'b0;
    else
      fired_reg <= fired_next;
  end

  // core enable off freezes all registers in place
  assign core_run_en = (state_reg == hspc_pkg::HSPC_RUN)
    || (state_reg == hspc_pkg::HSPC_WAKE_INT);
  assign core_reset = (state_reg == hspc_pkg::HSPC_IN_RESET)
    || in_standby;
  assign ram_hold = in_standby;
  assign osc_run = !in_standby;
  assign start_int_seq = (state_reg == hspc_pkg::HSPC_WAKE_INT)
    && instr_done && (steps_reg == 2'h1);
  assign pc_load = in_reset_leave;
  assign pc_load_value = hspc_pkg::RESET_VECTOR;
  // a pulse caught in the last halt cycle still arrives after wake
  assign count_event = (core_run_en && count_s && !count_prev_reg)
    || (halt_pulse_reg && !fired_reg && !core_reset);
  assign timer_run_en = core_run_en;
  assign test_pin_zero_o = t0_clk_enable && !in_standby
    && core_clk_phase;
  assign test_pin_zero_oe = t0_clk_enable && !in_standby;
  assign bus_oe = halted ? bus_mode_reg
    : (core_run_en && bus_out_mode);

  always_comb
  begin
    pin_strobes = core_strobes;
    if (!core_run_en)
    begin
      pin_strobes.latch_strobe = hspc_pkg::LATCH_STROBE_HALT;
      pin_strobes.program_fetch_strobe = hspc_pkg::CTRL_STROBE_HALT;
      pin_strobes.read_strobe = hspc_pkg::CTRL_STROBE_HALT;
      pin_strobes.write_strobe = hspc_pkg::CTRL_STROBE_HALT;
      pin_strobes.expander_strobe = hspc_pkg::CTRL_STROBE_HALT;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_halt_stops_core: assert property (
    (state_reg == hspc_pkg::HSPC_RUN && halt_exec && reset_s)
      |=> !core_run_en)
    else $error("halt did not stop core");
  chk_halt_strobes: assert property (
    halted |-> (pin_strobes.latch_strobe == 1'b0
      && pin_strobes.read_strobe && pin_strobes.write_strobe
      && pin_strobes.program_fetch_strobe))
    else $error("strobes wrong in halt");
  chk_halt_bus_mode: assert property (
    (state_reg == hspc_pkg::HSPC_RUN && halt_exec && reset_s)
      |=> (halted throughout (bus_oe == $past(bus_out_mode))) or !halted)
    else $error("bus mode lost in halt");
  chk_halt_osc_on: assert property (
    halted |-> osc_run && !timer_run_en)
    else $error("oscillator or timer wrong in halt");
  chk_t0_clock: assert property (
    (halted && t0_clk_enable) |-> test_pin_zero_oe)
    else $error("test pin clock stopped");
  chk_reset_exits: assert property (
    (halted && !reset_s) |=> core_reset)
    else $error("reset did not end halt");
  chk_int_dis_wake: assert property (
    (halted && !int_s && !int_enabled && reset_s) |=> core_run_en
      && !start_int_seq)
    else $error("disabled wake wrong");
  chk_int_en_wake: assert property (
    (halted && !int_s && int_enabled && reset_s)
      |=> state_reg == hspc_pkg::HSPC_WAKE_INT && steps_reg == 2'h2)
    else $error("enabled wake wrong");
  chk_standby_pin_ignored: assert property (
    (reset_s && !standby_s && state_reg == hspc_pkg::HSPC_RUN
      && !halt_exec) |=> state_reg == hspc_pkg::HSPC_RUN)
    else $error("standby taken with reset high");
  chk_standby_pin_ram: assert property (
    in_standby |-> ram_hold && !osc_run && core_reset)
    else $error("standby outputs wrong");
  chk_standby_pin_exit: assert property (
    (in_standby && standby_s) |=> state_reg == hspc_pkg::HSPC_IN_RESET)
    else $error("standby exit wrong");
  chk_standby_pin_restart: assert property (
    (state_reg == hspc_pkg::HSPC_IN_RESET && standby_s && reset_s)
      |-> pc_load && pc_load_value == hspc_pkg::RESET_VECTOR)
    else $error("restart vector wrong");

  cov_halt_int: cover property (halted ##1 !halted ##[1:10] start_int_seq);
  cov_halt_resume: cover property (halted ##1 !halted && core_run_en);
  cov_standby: cover property (in_standby ##1 !in_standby);
  cov_count_pulse: cover property (halted && count_event);

endmodule

// ==== tb/hspc_ext_ctrl.sv ====
/*
 model of the external reset, standby, interrupt and count circuitry.
 assumes the bench calls its tasks one at a time; pins move on negedge.
*/
`timescale 1ns/1ps
module hspc_ext_ctrl
(
  input wire logic clk,
  output logic reset_pin_b,
  output logic standby_pin,
  output logic int_pin_b,
  output logic count_input_pin
);
  // ----------------------------------------------------------------
  // pin sequences
  // ----------------------------------------------------------------
  initial
  begin
    reset_pin_b = 1'b1;
    standby_pin = 1'b1;
    int_pin_b = 1'b1;
    count_input_pin = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_reset(input int n);
    @(negedge clk) reset_pin_b = 1'b0;
    hold(n);
    reset_pin_b = 1'b1;
  endtask
  task automatic enter_standby();
    @(negedge clk) reset_pin_b = 1'b0;
    hold(4);
    standby_pin = 1'b0;
  endtask
  task automatic leave_standby();
    @(negedge clk) standby_pin = 1'b1;
    hold(4);
    reset_pin_b = 1'b1;
  endtask
  // misuse on purpose: standby dropped with reset still high
  task automatic stray_standby(input int n);
    @(negedge clk) standby_pin = 1'b0;
    hold(n);
    standby_pin = 1'b1;
  endtask
  task automatic int_low(input int n);
    @(negedge clk) int_pin_b = 1'b0;
    hold(n);
    int_pin_b = 1'b1;
  endtask
  task automatic count_pulse();
    @(negedge clk) count_input_pin = 1'b1;
    hold(2);
    count_input_pin = 1'b0;
  endtask
endmodule

// ==== tb/halt_standby_power_control_bench.sv ====
/*
 bench for the halt/standby controller; scenarios as tasks.
 assumes the external pins come from the hspc_ext_ctrl model.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(s, n) begin k = 0; while ((s) !== 1'b1 && k < n) \
  begin @(negedge clk); k++; end end
module halt_standby_power_control_bench;
  logic clk, rst_b, rp_b, sp, ip_b, cp;
  logic halt_exec, instr_done, int_enabled, counter_mode;
  logic t0_clk_enable, core_clk_phase, bus_out_mode;
  hspc_pkg::hspc_strobes_s core_strobes, pin_strobes;
  logic core_run_en, core_reset, ram_hold, osc_run, start_int_seq;
  logic [10:0] pc_load_value;
  logic pc_load, count_event, timer_run_en, t0_o, t0_oe, bus_oe;
  int n_fail, comparisons, k, n_cnt, n_int;

  hspc_ext_ctrl u_ext (.clk(clk), .reset_pin_b(rp_b), .standby_pin(sp),
    .int_pin_b(ip_b), .count_input_pin(cp));
  hspc_top u_dut (.clk(clk), .rst_b(rst_b), .reset_pin_b(rp_b),
    .standby_pin(sp), .int_pin_b(ip_b), .count_input_pin(cp),
    .halt_exec(halt_exec), .instr_done(instr_done),
    .int_enabled(int_enabled), .counter_mode(counter_mode),
    .t0_clk_enable(t0_clk_enable), .core_clk_phase(core_clk_phase),
    .bus_out_mode(bus_out_mode), .core_strobes(core_strobes),
    .core_run_en(core_run_en), .core_reset(core_reset),
    .ram_hold(ram_hold), .osc_run(osc_run), .start_int_seq(start_int_seq),
    .pc_load_value(pc_load_value), .pc_load(pc_load),
    .count_event(count_event), .timer_run_en(timer_run_en),
    .test_pin_zero_o(t0_o), .test_pin_zero_oe(t0_oe), .bus_oe(bus_oe),
    .pin_strobes(pin_strobes));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (count_event === 1'b1) n_cnt++;
    if (start_int_seq === 1'b1) n_int++;
  end

  task automatic do_halt();
    @(negedge clk) halt_exec = 1'b1;
    @(negedge clk) halt_exec = 1'b0;
    `CHK(core_run_en, 1'b0)
    `CHK(timer_run_en, 1'b0)
    `CHK(osc_run, 1'b1)
  endtask
  task automatic restart();
    `WAIT(pc_load, 12)
    `CHK(pc_load, 1'b1)
    `CHK(pc_load_value, 11'h000)
    `WAIT(core_run_en, 4)
    `CHK(core_run_en, 1'b1)
  endtask
  // strobes and bus must freeze even if the core shows other values
  task automatic t_halt_pins();
    bus_out_mode = 1'b1;
    t0_clk_enable = 1'b1;
    core_strobes = 5'h10;
    do_halt();
    bus_out_mode = 1'b0;
    @(negedge clk);
    `CHK(pin_strobes, hspc_pkg::hspc_strobes_s'(5'h0F))
    `CHK(bus_oe, 1'b1)
    `CHK(t0_oe, 1'b1)
    @(negedge clk) core_clk_phase = 1'b1;
    @(negedge clk);
    `CHK(t0_o, 1'b1)
    core_clk_phase = 1'b0;
    @(negedge clk);
    `CHK(t0_o, 1'b0)
  endtask
  // timer mode, no test clock, bus input: halt floats and stays quiet
  task automatic t_halt_quiet();
    counter_mode = 1'b0;
    t0_clk_enable = 1'b0;
    bus_out_mode = 1'b0;
    core_strobes = 5'h15;
    @(negedge clk);
    `CHK(pin_strobes, hspc_pkg::hspc_strobes_s'(5'h15))
    `CHK(timer_run_en, 1'b1)
    do_halt();
    n_cnt = 0;
    u_ext.count_pulse();
    u_ext.hold(3);
    `CHK(n_cnt, 0)
    `CHK(bus_oe, 1'b0)
    `CHK(t0_oe, 1'b0)
    `CHK(pin_strobes, hspc_pkg::hspc_strobes_s'(5'h0F))
    rst_b = 1'b0;
    @(negedge clk);
    `CHK(core_reset, 1'b1)
    `CHK(core_run_en, 1'b0)
    rst_b = 1'b1;
    restart();
  endtask
  task automatic t_count_wake_off();
    counter_mode = 1'b1;
    int_enabled = 1'b0;
    n_cnt = 0;
    n_int = 0;
    u_ext.count_pulse();
    u_ext.count_pulse();
    u_ext.hold(3);
    `CHK(n_cnt, 1)
    u_ext.int_low(2);
    `WAIT(core_run_en, 6)
    `CHK(core_run_en, 1'b1)
    u_ext.hold(4);
    `CHK(n_int, 0)
  endtask
  task automatic t_wake_int();
    int_enabled = 1'b1;
    do_halt();
    u_ext.int_low(2);
    `WAIT(core_run_en, 6)
    `CHK(core_run_en, 1'b1)
    instr_done = 1'b1;
    @(negedge clk) instr_done = 1'b0;
    `CHK(n_int, 0)
    @(negedge clk) instr_done = 1'b1;
    #1 `CHK(start_int_seq, 1'b1)
    @(negedge clk) instr_done = 1'b0;
  endtask
  task automatic t_reset_halt();
    do_halt();
    u_ext.pulse_reset(5);
    `CHK(core_reset, 1'b1)
    restart();
  endtask
  task automatic t_standby();
    u_ext.stray_standby(6);
    `CHK(ram_hold, 1'b0)
    `CHK(core_run_en, 1'b1)
    u_ext.enter_standby();
    `WAIT(ram_hold, 8)
    `CHK(ram_hold, 1'b1)
    `CHK(osc_run, 1'b0)
    u_ext.leave_standby();
    restart();
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(25 * 4000);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    {halt_exec, instr_done, int_enabled, counter_mode} = 4'h0;
    {t0_clk_enable, core_clk_phase, bus_out_mode} = 3'h0;
    core_strobes = 5'h0F;
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    restart();
    t_halt_pins();
    t_count_wake_off();
    t_wake_int();
    t_halt_quiet();
    t_reset_halt();
    t_standby();
    print_verdict();
  end
endmodule
